// *** sdc_regs.vh ***
`ifndef SDC_REGS_VH
`define SDC_REGS_VH

// frame layout
`define SDC_FRAME_BITS 16
`define SDC_CNT_FULL 5'h10
`define SDC_CH_BIT 15
`define SDC_CMD_HI 14
`define SDC_CMD_LO 13
`define SDC_CMD_SETPOINT 2'h0
`define SDC_CMD_DITHER 2'h1

// set point frame fields
`define SDC_SP_HI 9
`define SDC_SP_LO 0
`define SDC_DIAG_BIT 12
`define SDC_RANGE_BIT 11
`define SDC_CLIP_BIT 10

// dither frame fields
`define SDC_ED_BIT 12
`define SDC_DA_HI 11
`define SDC_DA_LO 7
`define SDC_DF_HI 6
`define SDC_DF_LO 0

// reset values
`define SDC_SP_RESET 10'h000
`define SDC_ED_RESET 1'h0
`define SDC_DA_RESET 5'h00
`define SDC_DF_RESET 7'h00
`define SDC_RESP_RESET 16'h0000

// set point scaling: switch point = code / 2^10 * 1230 mV
`define SDC_FULL_SCALE_MV 1230
// highest code below the 1178.35 mV saturation point
`define SDC_SP_SAT_CODE 10'h3d5
// code plus hysteresis above this lies beyond the upper limit
`define SDC_SP_HI_CODE 11'h3d6
// code below this plus hysteresis lies beyond the lower limit
`define SDC_SP_LO_CODE 11'h02a

`endif

// *** sdc_config.v ***
// Contract
// - average switch point is code/1024 times 1230 mV, saturating at 1178.35 mV.
// - near range ends, range error depends on hysteresis as well as code.
// - new set point or hysteresis takes effect at frame select rising edge.
// - a new set point or hysteresis leaves the dither phase running.
// - dither frame B12 enables enhanced dither; resets to zero.
// - dither frame B11..B7 is the amplitude code; resets to zero.
// - dither frame B6..B0 is the frequency code; resets to zero.
// - dither response echoes enhanced bit and shadow amplitude and frequency.
// - new amplitude or frequency applies at start of next dither period.
// - B15 selects channel; B14..B13 select command, 00 set point, 01 dither.
// - set point frame B9..B0 holds the 10-bit current code, reset zero.
// - set point response B11 flags switch point beyond the valid range.
`timescale 1ns/10ps
`default_nettype none
`include "sdc_regs.vh"

module sdc_config
(
  // system
  input wire clk_sys_i,
  input wire nrst_i,
  // serial link pins
  input wire frame_select_n_i,
  input wire spi_clk_i,
  input wire spi_mosi_i,
  output reg spi_miso_o,
  output wire spi_miso_oe_o,
  // per-channel status from the power stage
  input wire [3:0] hyst_ch0_i,
  input wire [3:0] hyst_ch1_i,
  input wire diag_err_ch0_i,
  input wire diag_err_ch1_i,
  input wire dither_clip_ch0_i,
  input wire dither_clip_ch1_i,
  input wire dither_period_start_ch0_i,
  input wire dither_period_start_ch1_i,
  // channel 0 settings
  output reg [9:0] average_switch_point_ch0_o,
  output reg range_error_flag_ch0_o,
  output reg enhanced_dither_enable_ch0_o,
  output reg [4:0] dither_amplitude_code_ch0_o,
  output reg [6:0] dither_frequency_code_ch0_o,
  // channel 1 settings
  output reg [9:0] average_switch_point_ch1_o,
  output reg range_error_flag_ch1_o,
  output reg enhanced_dither_enable_ch1_o,
  output reg [4:0] dither_amplitude_code_ch1_o,
  output reg [6:0] dither_frequency_code_ch1_o
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // bit 2 frame select, bit 1 link clock, bit 0 data in
  reg [2:0] pin_s1;
  reg [2:0] pin_s2;
  reg [2:0] pin_s3;
  reg [2:0] pin_lvl;
  // a level change counts once stages two and three agree
  wire [2:0] pin_agree = ~(pin_s2 ^ pin_s3);
  wire [2:0] next_pin_lvl = (pin_agree & pin_s3) | (~pin_agree & pin_lvl);
  // first stage feeds only the second stage
  always @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      pin_s1 <= 3'h5;
      pin_s2 <= 3'h5;
      pin_s3 <= 3'h5;
      pin_lvl <= 3'h5;
    end
    else
    begin
      pin_s1 <= {frame_select_n_i, spi_clk_i, spi_mosi_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_lvl <= next_pin_lvl;
    end
  end
  // synced edges and levels
  wire fs_fall = pin_lvl[2] & ~next_pin_lvl[2];
  wire fs_rise = ~pin_lvl[2] & next_pin_lvl[2];
  wire sck_rise = ~pin_lvl[1] & next_pin_lvl[1];
  wire sck_fall = pin_lvl[1] & ~next_pin_lvl[1];
  wire selected = ~pin_lvl[2];
  wire mosi_bit = next_pin_lvl[0];
  // ----------------------------------------
  // frame shifter
  // ----------------------------------------
  reg [15:0] rx_shift;
  reg [15:0] tx_shift;
  reg [15:0] resp_word;
  reg [4:0] bit_cnt;
  // miso is driven only while the frame is selected
  assign spi_miso_oe_o = selected;
  // shift in on link clock rise, shift out on fall, msb first
  always @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      rx_shift <= `SDC_RESP_RESET;
      tx_shift <= `SDC_RESP_RESET;
      bit_cnt <= 5'h00;
      spi_miso_o <= 1'b0;
    end
    else if (fs_fall)
    begin
      bit_cnt <= 5'h00;
      tx_shift <= {resp_word[14:0], 1'b0};
      spi_miso_o <= resp_word[15];
    end
    else if (selected)
    begin
      if (sck_rise)
      begin
        rx_shift <= {rx_shift[14:0], mosi_bit};
        // count saturates so an overlong frame never wraps back to sixteen
        bit_cnt <= (bit_cnt == 5'h1f) ? bit_cnt : bit_cnt + 5'h01;
      end
      if (sck_fall)
      begin
        spi_miso_o <= tx_shift[15];
        tx_shift <= {tx_shift[14:0], 1'b0};
      end
    end
  end
  // ----------------------------------------
  // command decode
  // ----------------------------------------
  // sixteen bits then rise
  wire frame_ok = fs_rise & (bit_cnt == `SDC_CNT_FULL);
  wire cmd_ch = rx_shift[`SDC_CH_BIT];
  wire [1:0] cmd_type = rx_shift[`SDC_CMD_HI:`SDC_CMD_LO];
  wire do_sp = frame_ok & (cmd_type == `SDC_CMD_SETPOINT);
  wire do_dither = frame_ok & (cmd_type == `SDC_CMD_DITHER);
  // ----------------------------------------
  // per-channel settings
  // ----------------------------------------
  reg [9:0] sp_code [0:1];
  reg [3:0] hyst_act [0:1];
  reg ed_reg [0:1];
  reg [4:0] da_shadow [0:1];
  reg [6:0] df_shadow [0:1];
  wire [1:0] period_start = {dither_period_start_ch1_i, dither_period_start_ch0_i};
  integer ch;
  // set point, hysteresis and dither shadows per channel
  always @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      for (ch = 0; ch < 2; ch = ch + 1)
      begin
        sp_code[ch] <= `SDC_SP_RESET;
        hyst_act[ch] <= 4'h0;
        ed_reg[ch] <= `SDC_ED_RESET;
        da_shadow[ch] <= `SDC_DA_RESET;
        df_shadow[ch] <= `SDC_DF_RESET;
      end
    end
    else
    begin
      if (do_sp)
      begin
        sp_code[cmd_ch] <= rx_shift[`SDC_SP_HI:`SDC_SP_LO];
      end
      if (frame_ok)
      begin
        hyst_act[0] <= hyst_ch0_i;
        hyst_act[1] <= hyst_ch1_i;
      end
      if (do_dither)
      begin
        ed_reg[cmd_ch] <= rx_shift[`SDC_ED_BIT];
        da_shadow[cmd_ch] <= rx_shift[`SDC_DA_HI:`SDC_DA_LO];
        df_shadow[cmd_ch] <= rx_shift[`SDC_DF_HI:`SDC_DF_LO];
      end
    end
  end
  // ----------------------------------------
  // switch point and range check
  // ----------------------------------------
  wire [10:0] sum0 = {1'b0, sp_code[0]} + {7'h00, hyst_act[0]};
  wire [10:0] sum1 = {1'b0, sp_code[1]} + {7'h00, hyst_act[1]};
  wire [10:0] low0 = `SDC_SP_LO_CODE + {7'h00, hyst_act[0]};
  wire [10:0] low1 = `SDC_SP_LO_CODE + {7'h00, hyst_act[1]};
  wire range0 = (sp_code[0] != 10'h000) &
    ((sum0 > `SDC_SP_HI_CODE) | ({1'b0, sp_code[0]} < low0));
  wire range1 = (sp_code[1] != 10'h000) &
    ((sum1 > `SDC_SP_HI_CODE) | ({1'b0, sp_code[1]} < low1));
  always @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      average_switch_point_ch0_o <= `SDC_SP_RESET;
      average_switch_point_ch1_o <= `SDC_SP_RESET;
      range_error_flag_ch0_o <= 1'b0;
      range_error_flag_ch1_o <= 1'b0;
    end
    else
    begin
      average_switch_point_ch0_o <= (sp_code[0] > `SDC_SP_SAT_CODE) ?
        `SDC_SP_SAT_CODE : sp_code[0];
      average_switch_point_ch1_o <= (sp_code[1] > `SDC_SP_SAT_CODE) ?
        `SDC_SP_SAT_CODE : sp_code[1];
      range_error_flag_ch0_o <= range0;
      range_error_flag_ch1_o <= range1;
    end
  end
  // ----------------------------------------
  // active dither settings
  // ----------------------------------------
  // no dither restart on set point change
  always @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      enhanced_dither_enable_ch0_o <= `SDC_ED_RESET;
      enhanced_dither_enable_ch1_o <= `SDC_ED_RESET;
      dither_amplitude_code_ch0_o <= `SDC_DA_RESET;
      dither_amplitude_code_ch1_o <= `SDC_DA_RESET;
      dither_frequency_code_ch0_o <= `SDC_DF_RESET;
      dither_frequency_code_ch1_o <= `SDC_DF_RESET;
    end
    else
    begin
      enhanced_dither_enable_ch0_o <= ed_reg[0];
      enhanced_dither_enable_ch1_o <= ed_reg[1];
      if (period_start[0])
      begin
        dither_amplitude_code_ch0_o <= da_shadow[0];
        dither_frequency_code_ch0_o <= df_shadow[0];
      end
      if (period_start[1])
      begin
        dither_amplitude_code_ch1_o <= da_shadow[1];
        dither_frequency_code_ch1_o <= df_shadow[1];
      end
    end
  end
  // ----------------------------------------
  // response for the next frame
  // ----------------------------------------
  reg [15:0] next_resp;
  wire [1:0] diag_in = {diag_err_ch1_i, diag_err_ch0_i};
  wire [1:0] clip_in = {dither_clip_ch1_i, dither_clip_ch0_i};
  wire [9:0] new_sp = rx_shift[`SDC_SP_HI:`SDC_SP_LO];
  wire [3:0] new_hyst = cmd_ch ? hyst_ch1_i : hyst_ch0_i;
  wire [10:0] new_sum = {1'b0, new_sp} + {7'h00, new_hyst};
  wire [10:0] new_low = `SDC_SP_LO_CODE + {7'h00, new_hyst};
  wire new_range = (new_sp != 10'h000) &
    ((new_sum > `SDC_SP_HI_CODE) | ({1'b0, new_sp} < new_low));
  // build the echo word from the settings as they stand after this frame
  always @*
  begin
    next_resp = {rx_shift[15:13], 13'h0000};
    if (cmd_type == `SDC_CMD_SETPOINT)
    begin
      next_resp[`SDC_DIAG_BIT] = diag_in[cmd_ch];
      next_resp[`SDC_RANGE_BIT] = new_range;
      next_resp[`SDC_CLIP_BIT] = clip_in[cmd_ch];
      next_resp[`SDC_SP_HI:`SDC_SP_LO] = new_sp;
    end
    else if (cmd_type == `SDC_CMD_DITHER)
    begin
      next_resp[`SDC_ED_BIT] = rx_shift[`SDC_ED_BIT];
      next_resp[`SDC_DA_HI:`SDC_DA_LO] = rx_shift[`SDC_DA_HI:`SDC_DA_LO];
      next_resp[`SDC_DF_HI:`SDC_DF_LO] = rx_shift[`SDC_DF_HI:`SDC_DF_LO];
    end
  end
  // response register, replaced only by a complete frame
  always @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      resp_word <= `SDC_RESP_RESET;
    end
    else if (frame_ok)
    begin
      resp_word <= next_resp;
    end
  end
endmodule
`default_nettype wire

// *** sdc_config_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------------
// port checker
// ------------
module sdc_config_sva
(
  // clock and reset
  input wire clk_sys_i,
  input wire nrst_i,
  // watched ports
  input wire frame_select_n_i,
  input wire spi_miso_oe_o,
  input wire dither_period_start_ch0_i,
  input wire [9:0] average_switch_point_ch0_o,
  input wire [9:0] average_switch_point_ch1_o,
  input wire range_error_flag_ch0_o,
  input wire [4:0] dither_amplitude_code_ch0_o,
  input wire [6:0] dither_frequency_code_ch0_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  // output enable follows the frame
  a_oe_in_frame: assert property ((!frame_select_n_i) [*5] |-> spi_miso_oe_o)
    else $error("oe low in frame");
  a_oe_off_idle: assert property (frame_select_n_i [*5] |-> !spi_miso_oe_o)
    else $error("oe high outside frame");
  // set point saturation and timing
  a_sp_sat_ch0: assert property (average_switch_point_ch0_o <= 10'h3d5)
    else $error("ch0 set point above ceiling");
  a_sp_sat_ch1: assert property (average_switch_point_ch1_o <= 10'h3d5)
    else $error("ch1 set point above ceiling");
  a_sp_still_frame: assert property ((!frame_select_n_i) [*8]
    |=> $stable(average_switch_point_ch0_o)) else $error("set point moved in frame");
  a_range_low_code: assert property ($stable(average_switch_point_ch0_o)
    && average_switch_point_ch0_o != 10'h000 && average_switch_point_ch0_o < 10'h02a
    |-> range_error_flag_ch0_o) else $error("low code not flagged");
  // dither changes only at a period start
  a_amp_at_period: assert property ($changed(dither_amplitude_code_ch0_o)
    |-> $past(dither_period_start_ch0_i) || $past(dither_period_start_ch0_i, 2))
    else $error("amplitude moved off period");
  a_freq_at_period: assert property ($changed(dither_frequency_code_ch0_o)
    |-> $past(dither_period_start_ch0_i) || $past(dither_period_start_ch0_i, 2))
    else $error("frequency moved off period");
endmodule
`default_nettype wire

// *** sdc_spi_master.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------------
// link master
// ------------
module sdc_spi_master
(
  // system
  input wire clk_sys_i,
  // link pins
  output logic frame_select_n_o,
  output logic spi_clk_o,
  output logic spi_mosi_o,
  input wire spi_miso_i
);
  // idle levels, link clock stands low
  initial
  begin
    frame_select_n_o = 1'b1;
    spi_clk_o = 1'b0;
    spi_mosi_o = 1'b1;
  end
  // frame of up to sixteen bits
  // n bits msb first; answer sampled late in the high phase
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    logic [15:0] sh;
    sh = tx;
    rx = 16'h0000;
    frame_select_n_o <= 1'b0;
    spi_mosi_o <= sh[15];
    repeat (4) @(posedge clk_sys_i);
    for (int i = 0; i < n; i++)
    begin
      repeat (4) @(posedge clk_sys_i);
      spi_clk_o <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      rx = {rx[14:0], spi_miso_i};
      sh = sh << 1;
      spi_clk_o <= 1'b0;
      spi_mosi_o <= sh[15];
    end
    repeat (4) @(posedge clk_sys_i);
    // released data line shows the inverse
    frame_select_n_o <= 1'b1;
    spi_mosi_o <= ~spi_mosi_o;
    repeat (10) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// *** sdc_config_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
// ------------
// bench top
// ------------
module sdc_config_tb_top;
  // design inputs
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] hyst_ch0_i = 4'h0, hyst_ch1_i = 4'h0;
  logic diag_err_ch0_i = 1'b0, diag_err_ch1_i = 1'b0, dither_clip_ch0_i = 1'b0;
  logic dither_clip_ch1_i = 1'b0, dither_period_start_ch0_i = 1'b0;
  logic dither_period_start_ch1_i = 1'b0;
  // link and outputs
  wire frame_select_n_i, spi_clk_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o, miso_line;
  wire range_error_flag_ch0_o, range_error_flag_ch1_o;
  wire enhanced_dither_enable_ch0_o, enhanced_dither_enable_ch1_o;
  wire [9:0] average_switch_point_ch0_o, average_switch_point_ch1_o;
  wire [4:0] dither_amplitude_code_ch0_o, dither_amplitude_code_ch1_o;
  wire [6:0] dither_frequency_code_ch0_o, dither_frequency_code_ch1_o;
  wire [23:0] st0 = {average_switch_point_ch0_o, range_error_flag_ch0_o,
    enhanced_dither_enable_ch0_o, dither_amplitude_code_ch0_o, dither_frequency_code_ch0_o};
  wire [23:0] st1 = {average_switch_point_ch1_o, range_error_flag_ch1_o,
    enhanced_dither_enable_ch1_o, dither_amplitude_code_ch1_o, dither_frequency_code_ch1_o};
  // bench state
  int fail_count = 0, checked = 0, cycles = 0;
  logic [15:0] rx;
  logic [15:0] prev = 16'h0000;
  // expected range flags of the eight set point frames
  logic er [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [9:0] cd [8] = '{10'h14d, 10'h029, 10'h02a, 10'h02a, 10'h3d5, 10'h3d5, 10'h3ff, 10'h000};
  logic [3:0] hy [8] = '{4'h1, 4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h0, 4'hf};
  // miso pulled up while floating
  assign miso_line = spi_miso_oe_o ? spi_miso_o : 1'b1;
  sdc_config u_sdc_config (.*);
  sdc_spi_master u_sdc_spi_master (.clk_sys_i(clk_sys_i), .frame_select_n_o(frame_select_n_i),
    .spi_clk_o(spi_clk_i), .spi_mosi_o(spi_mosi_i), .spi_miso_i(miso_line));
  // clock and timeout
  always #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one period start pulse per set bit
  task automatic pulse(input logic [1:0] m);
    {dither_period_start_ch1_i, dither_period_start_ch0_i} <= m;
    @(posedge clk_sys_i);
    {dither_period_start_ch1_i, dither_period_start_ch0_i} <= 2'b00;
    repeat (3) @(posedge clk_sys_i);
  endtask
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    `CHK({st0, st1, spi_miso_oe_o}, 49'h0)
    for (int i = 0; i < 8; i++)
    begin
      hyst_ch0_i <= hy[i];
      u_sdc_spi_master.xfer({6'h00, cd[i]}, 16, rx);
      `CHK(st0[23:13], {(cd[i] > 10'h3d5 ? 10'h3d5 : cd[i]), er[i]})
      `CHK(rx, prev)
      prev = {4'h0, er[i], 1'b0, cd[i]};
    end
    diag_err_ch1_i <= 1'b1;
    dither_clip_ch1_i <= 1'b1;
    u_sdc_spi_master.xfer(16'h80a6, 16, rx);
    `CHK(rx, prev)
    `CHK({st0[23:13], st1[23:13]}, {11'h000, 10'h0a6, 1'b0})
    u_sdc_spi_master.xfer(16'h3ad5, 16, rx);
    `CHK(rx, 16'h94a6)
    `CHK(st0[12:0], 13'h1000)
    pulse(2'b01);
    `CHK(st0[12:0], {1'b1, 5'h15, 7'h55})
    u_sdc_spi_master.xfer(16'h01f3, 16, rx);
    `CHK(rx, 16'h3ad5)
    `CHK(st0, {10'h1f3, 1'b0, 1'b1, 5'h15, 7'h55})
    u_sdc_spi_master.xfer(16'h0000, 15, rx);
    `CHK(st0[23:13], {10'h1f3, 1'b0})
    u_sdc_spi_master.xfer(16'h2000, 16, rx);
    `CHK(rx, 16'h01f3)
    pulse(2'b10);
    `CHK({st0[12:0], st1[12:0]}, {1'b0, 5'h15, 7'h55, 13'h0000})
    pulse(2'b01);
    `CHK(st0[12:0], 13'h0000)
    u_sdc_spi_master.xfer(16'hb0c3, 16, rx);
    `CHK(rx, 16'h2000)
    pulse(2'b10);
    `CHK({st0[12:0], st1[12:0]}, {13'h0000, 1'b1, 5'h01, 7'h43})
    u_sdc_spi_master.xfer(16'h7fff, 16, rx);
    `CHK(rx, 16'hb0c3)
    `CHK({st0, st1[23:13]}, {10'h1f3, 1'b0, 13'h0000, 10'h0a6, 1'b0})
    u_sdc_spi_master.xfer(16'h2000, 16, rx);
    `CHK(rx, 16'h6000)
    print_verdict();
  end
endmodule
bind sdc_config sdc_config_sva u_sdc_config_sva (.*);
`default_nettype wire
